/* File: hdl/eism_map.vh */
/*
  Register offsets, field layout, reset values and source codes for the
  external interrupt source selector.
  Assumes a 32-bit classic Wishbone slave with byte addressing.
*/
`ifndef EISM_MAP_VH
`define EISM_MAP_VH

// ==========================================================================
// register offsets (byte addresses)
`define EISM_OFS_SEL_0_3 8'h08
`define EISM_OFS_SEL_4_7 8'h0C
`define EISM_OFS_SEL_8_11 8'h10

// ==========================================================================
// field layout and reset
`define EISM_FIELD_W 4
`define EISM_LINES_PER_REG 4
`define EISM_NUM_LINES 12
`define EISM_USED_BITS 16
`define EISM_SEL_RESET 16'h0000

// ==========================================================================
// source codes
`define EISM_CODE_PORT_A 4'h0
`define EISM_CODE_PORT_B 4'h1
`define EISM_CODE_PORT_F 4'h5

// lines with a port F source: 0, 1, 2, 6, 7
`define EISM_PORT_F_LINES 12'h0C7

`endif

/* File: hdl/eism_ext_irq_source_mux.v */
/*
  External interrupt source selector: three selector registers on a classic
  Wishbone slave, and a per-line pin multiplexer feeding the interrupt
  controller.
  Assumes port pins are asynchronous to clk_i and the interrupt controller
  samples ext_irq_line_o on clk_i.
*/
// Implementation choice: register access over Wishbone.
`timescale 1ns/10ps
`default_nettype none
`include "eism_map.vh"

module eism_ext_irq_source_mux (
  input wire clk_i,
  input wire rst_i,
  input wire cyc_i,
  input wire stb_i,
  input wire we_i,
  input wire [7:0] adr_i,
  input wire [3:0] sel_i,
  input wire [31:0] dat_i,
  output reg [31:0] dat_o,
  output reg ack_o,
  output reg err_o,
  input wire [11:0] port_a_pin_i,
  input wire [11:0] port_b_pin_i,
  input wire [11:0] port_f_pin_i,
  output reg [11:0] ext_irq_line_o
);

  // ========================================================================
  // pin synchronisers
  reg [11:0] pa_meta_q;
  reg [11:0] pa_sync_q;
  reg [11:0] pb_meta_q;
  reg [11:0] pb_sync_q;
  reg [11:0] pf_meta_q;
  reg [11:0] pf_sync_q;

  always @(posedge clk_i) begin
    if (rst_i) begin
      pa_meta_q <= 12'h000;
      pa_sync_q <= 12'h000;
      pb_meta_q <= 12'h000;
      pb_sync_q <= 12'h000;
      pf_meta_q <= 12'h000;
      pf_sync_q <= 12'h000;
    end else begin
      pa_meta_q <= port_a_pin_i;
      pa_sync_q <= pa_meta_q;
      pb_meta_q <= port_b_pin_i;
      pb_sync_q <= pb_meta_q;
      pf_meta_q <= port_f_pin_i;
      pf_sync_q <= pf_meta_q;
    end
  end

  // ========================================================================
  // selector registers
  reg [15:0] sel_0_3_q;
  reg [15:0] sel_4_7_q;
  reg [15:0] sel_8_11_q;
  wire req = cyc_i & stb_i & ~ack_o & ~err_o;
  wire hit_0 = (adr_i == `EISM_OFS_SEL_0_3);
  wire hit_1 = (adr_i == `EISM_OFS_SEL_4_7);
  wire hit_2 = (adr_i == `EISM_OFS_SEL_8_11);
  wire hit = hit_0 | hit_1 | hit_2;

  // byte-lane merge; upper lanes have no storage
  function [15:0] merge;
    input [15:0] old;
    input [31:0] wd;
    input [3:0] be;
    begin
      merge[7:0] = be[0] ? wd[7:0] : old[7:0];
      merge[15:8] = be[1] ? wd[15:8] : old[15:8];
    end
  endfunction

  always @(posedge clk_i) begin
    if (rst_i) begin
      sel_0_3_q <= `EISM_SEL_RESET;
      sel_4_7_q <= `EISM_SEL_RESET;
      sel_8_11_q <= `EISM_SEL_RESET;
    end else if (req & we_i) begin
      if (hit_0)
        sel_0_3_q <= merge(sel_0_3_q, dat_i, sel_i);
      if (hit_1)
        sel_4_7_q <= merge(sel_4_7_q, dat_i, sel_i);
      if (hit_2)
        sel_8_11_q <= merge(sel_8_11_q, dat_i, sel_i);
    end
  end

  // ========================================================================
  // bus answer: one wait-free ack/err in the cycle after the request
  reg [15:0] rd_mux;
  always @* begin
    rd_mux = 16'h0000;
    if (hit_0)
      rd_mux = sel_0_3_q;
    else if (hit_1)
      rd_mux = sel_4_7_q;
    else if (hit_2)
      rd_mux = sel_8_11_q;
  end

  always @(posedge clk_i) begin
    if (rst_i) begin
      ack_o <= 1'b0;
      err_o <= 1'b0;
      dat_o <= 32'h0000_0000;
    end else begin
      ack_o <= req & hit;
      err_o <= req & ~hit;
      // upper bits read zero; leaves them unstored
      dat_o <= (req & hit & ~we_i) ? {16'h0000, rd_mux} : 32'h0000_0000;
    end
  end

  // ========================================================================
  // source selection per line
  wire [47:0] all_sel = {sel_8_11_q, sel_4_7_q, sel_0_3_q};
  // a macro literal cannot be bit-selected, so give it a name first
  localparam [11:0] PORT_F_LINES = `EISM_PORT_F_LINES;
  reg [11:0] line_d;
  reg [3:0] code;
  integer n;

  always @* begin
    line_d = 12'h000;
    code = 4'h0;
    for (n = 0; n < `EISM_NUM_LINES; n = n + 1) begin
      code = all_sel[n*`EISM_FIELD_W +: `EISM_FIELD_W];
      case (code)
        `EISM_CODE_PORT_A: line_d[n] = pa_sync_q[n];
        `EISM_CODE_PORT_B: line_d[n] = pb_sync_q[n];
        `EISM_CODE_PORT_F: line_d[n] = pf_sync_q[n] & PORT_F_LINES[n];
        default: line_d[n] = 1'b0;
      endcase
    end
  end

  always @(posedge clk_i) begin
    if (rst_i)
      ext_irq_line_o <= 12'h000;
    else
      ext_irq_line_o <= line_d;
  end

endmodule // eism_ext_irq_source_mux
`default_nettype wire

/* File: verif/eism_sva.sv */
/* bus answer checker for the selector
   bound to its top module */
`timescale 1ns/10ps
`default_nettype none
module eism_sva (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic cyc_i,
  input wire logic [7:0] adr_i,
  input wire logic [31:0] dat_o,
  input wire logic ack_o,
  input wire logic err_o
);
  default clocking @(posedge clk_i); endclocking
  default disable iff (rst_i);
  // a request counts only while no answer is out
  wire tk = cyc_i & ~ack_o & ~err_o;
  sequence s_ack; ack_o && !err_o; endsequence
  chk_map_08: assert property (tk && adr_i == 8'h08 |=> s_ack) else $error("08");
  chk_map_0c: assert property (tk && adr_i == 8'h0C |=> s_ack) else $error("0c");
  chk_map_10: assert property (tk && adr_i == 8'h10 |=> s_ack) else $error("10");
  chk_hi_zero: assert property (ack_o |-> dat_o[31:16] == 16'h0000) else $error("hi");
  chk_ack_once: assert property (ack_o |=> !ack_o) else $error("ack");
  chk_err_once: assert property (err_o |=> !err_o) else $error("err");
  chk_idle_quiet: assert property (!cyc_i |=> !ack_o && !err_o) else $error("idle");
  chk_dat_idle: assert property (!ack_o |-> dat_o == 32'h0000_0000) else $error("dat");
endmodule // eism_sva
bind eism_ext_irq_source_mux eism_sva u_eism_sva (.*);
`default_nettype wire

/* File: verif/eism_ext_irq_source_mux_test.sv */
/* selector bench: bus tasks, pin checks
   needs the block and its checker */
`timescale 1ns/10ps
`default_nettype none
module eism_ext_irq_source_mux_test;
  logic clk_i = 0, rst_i = 1, cyc_i = 0, we_i = 0, ack_o, err_o;
  logic [7:0] adr_i = 0;
  logic [31:0] dat_i = 0, dat_o;
  logic [11:0] pa = 12'h0A5, pb = 12'h050, pf = 12'hFFF, ln;
  logic [15:0] pv = 0, pt [5] = '{16'h0000, 16'h1111, 16'h5555, 16'h2222, 16'h5210};
  // ========
  // expected lines per pattern, from the pin values above
  logic [11:0] xp [5] = '{12'h0A5, 12'h050, 12'h0C7, 12'h000, 12'h081};
  int err_total = 0, n_tests = 0;
  eism_ext_irq_source_mux u_eism_ext_irq_source_mux (.clk_i, .rst_i, .cyc_i, .stb_i(cyc_i),
    .we_i, .adr_i, .sel_i(4'hF), .dat_i, .dat_o, .ack_o, .err_o, .port_a_pin_i(pa),
    .port_b_pin_i(pb), .port_f_pin_i(pf), .ext_irq_line_o(ln));
  initial forever #10 clk_i = ~clk_i;
  task automatic chk(string s, logic [31:0] g, e);
    n_tests++;
    if (g !== e) $display("[FAIL] %s exp %h seen %h", s, e, g);
    err_total += int'(g !== e);
  endtask
  task automatic bus(logic w, int r, logic [15:0] d);
    cyc_i <= 1;
    we_i <= w;
    adr_i <= 8'(8 + 4 * r);
    dat_i <= {16'h0000, d};
    do @(posedge clk_i); while (ack_o !== 1'b1 && err_o !== 1'b1);
    chk("answer", {ack_o, err_o}, (r < 3) ? 2'b10 : 2'b01);
    if (!w && r < 3) chk("readback", dat_o, {16'h0000, d});
    cyc_i <= 0;
    @(posedge clk_i);
  endtask
  task automatic report_and_stop;
    $display("%0d checks %0d bad", n_tests, err_total);
    if (err_total == 0 && n_tests > 0) $display("*** PASS ***");
    else $display("*** FAIL ***");
    $finish;
  endtask
  initial begin
    #20000 err_total++;
    report_and_stop;
  end
  initial begin
    repeat (12) @(posedge clk_i);
    rst_i <= 0;
    @(posedge clk_i);
    foreach (pt[p]) begin
      for (int r = 0; r < 3; r++) begin
        bus(0, r, pv);
        bus(1, r, pt[p]);
      end
      pv = pt[p];
      repeat (4) @(posedge clk_i);
      chk("lines", ln, xp[p]);
      $display("test %h done", pv);
    end
    bus(1, 3, 16'hFFFF);
    bus(0, 3, 16'h0000);
    bus(0, 0, pv);
    $display("test unmapped done");
    report_and_stop;
  end
endmodule // eism_ext_irq_source_mux_test
`default_nettype wire
